// [src/sild_pkg.sv]
// shared constants of the serial-input latched driver
// assumes nothing beyond a systemverilog compiler
package sild_pkg;
  localparam int          SILD_CHANNELS   = 32;     // shift stages, latches and drivers
  localparam int          SILD_FIFO_DEPTH = 16;     // snapshot buffer depth
  localparam logic [31:0] SILD_WORD_RST   = 32'h0000_0000;
  localparam logic        SILD_BIT_RST    = 1'b0;
  localparam logic        SILD_BIT_SET    = 1'b1;
endpackage

// [src/sild_fifo_if.sv]
// handshake bundle between the driver core and its snapshot buffer
// assumes write side on the serial clock, read side on the core clock
`timescale 1ns/1ps
`default_nettype none
interface sild_fifo_if #(parameter int WIDTH = 32);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport buffer   (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport producer (output wr_valid, wr_data, input wr_ready);
  modport consumer (output rd_ready, input rd_valid, rd_data);
endinterface
`default_nettype wire

// [src/sild_async_fifo.sv]
// dual-clock fifo with gray-coded pointers and registered read data
// assumes each reset is already released in step with its own clock
`timescale 1ns/1ps
`default_nettype none
module sild_async_fifo
  import sild_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic     wr_clk,
  input wire logic     wr_rst_n,
  input wire logic     rd_clk,
  input wire logic     rd_rst_n,
  sild_fifo_if.buffer  bus
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_r, wgray_r, rbin_r, rgray_r;
  logic [AW:0]      rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
  logic [AW:0]      wbin_nxt, rbin_nxt;
  logic             full, empty, wr_go, rd_go;
  logic             full_r;
  logic             rd_valid_r;
  logic [WIDTH-1:0] rd_data_r;

  // ************************************************************
  // write side
  // ************************************************************
  assign full     = (wgray_r == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
  assign wr_go    = bus.wr_valid && !full;
  assign wbin_nxt = wbin_r + (AW+1)'(wr_go);

  // pointer update and storage
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_r  <= '0;
      wgray_r <= '0;
    end else begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_go) begin
      mem[wbin_r[AW-1:0]] <= bus.wr_data;
    end
  end

  // read pointer into write domain, two flops
  always_ff @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      rg_s1_r <= '0;
      rg_s2_r <= '0;
      full_r  <= SILD_BIT_RST;
    end else begin
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
      full_r  <= (wbin_nxt ^ (wbin_nxt >> 1)) == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
    end
  end
  assign bus.wr_ready = !full_r && !full;

  // ************************************************************
  // read side
  // ************************************************************
  assign empty    = (rgray_r == wg_s2_r);
  assign rd_go    = !empty && (!rd_valid_r || bus.rd_ready);
  assign rbin_nxt = rbin_r + (AW+1)'(rd_go);

  // write pointer into read domain, two flops
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end

  // pointer and output stage
  always_ff @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_r     <= '0;
      rgray_r    <= '0;
      rd_valid_r <= SILD_BIT_RST;
    end else begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      if (rd_go) begin
        rd_valid_r <= SILD_BIT_SET;
      end else if (bus.rd_ready) begin
        rd_valid_r <= SILD_BIT_RST;
      end
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_go) begin
      rd_data_r <= mem[rbin_r[AW-1:0]];
    end
  end
  assign bus.rd_valid = rd_valid_r;
  assign bus.rd_data  = rd_data_r;
endmodule
`default_nettype wire

// [src/sild_driver.sv]
// serial-input latched sink driver: shift chain, latches, output gating
// assumes ser_clk comes from the host and may stop between frames;
// strobe and output enable are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module sild_driver
  import sild_pkg::*;
#(
  parameter int CHANNELS = SILD_CHANNELS,
  parameter int DEPTH    = SILD_FIFO_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic                ser_clk,
  input  wire logic                ser_data_in,
  input  wire logic                strobe,
  input  wire logic                out_enable,
  output logic                     ser_data_out,
  output logic                     ser_ready,
  output logic [CHANNELS-1:0]      drive_on
);
  sild_fifo_if #(.WIDTH(CHANNELS)) snap ();

  logic                rst_c1_r, rst_c2_r;
  logic                rst_s1_r, rst_s2_r;
  logic [CHANNELS-1:0] shift_r, shift_nxt;
  logic                ready_r;
  logic                stb_s1_r, stb_s2_r;
  logic                oe_s1_r, oe_s2_r;
  logic [CHANNELS-1:0] mirror_r;
  logic [CHANNELS-1:0] latch_r;
  logic [CHANNELS-1:0] drive_r;

  // ************************************************************
  // reset release
  // ************************************************************
  // core domain copy of the reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_c1_r <= SILD_BIT_RST;
      rst_c2_r <= SILD_BIT_RST;
    end else begin
      rst_c1_r <= SILD_BIT_SET;
      rst_c2_r <= rst_c1_r;
    end
  end

  // serial domain copy, released on the host clock
  always_ff @(posedge ser_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= SILD_BIT_RST;
      rst_s2_r <= SILD_BIT_RST;
    end else begin
      rst_s1_r <= SILD_BIT_SET;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ************************************************************
  // shift chain on the serial clock
  // ************************************************************
  // new bit enters stage zero, the rest move up one
  assign shift_nxt = {shift_r[CHANNELS-2:0], ser_data_in};

  // data pin is sampled straight on the link clock rise
  always_ff @(posedge ser_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      shift_r      <= CHANNELS'(SILD_WORD_RST);
      ser_data_out <= SILD_BIT_RST;
    end else begin
      shift_r      <= shift_nxt;
      ser_data_out <= shift_nxt[CHANNELS-1];
    end
  end

  // each edge offers the whole chain as a snapshot
  assign snap.wr_valid = rst_s2_r;
  assign snap.wr_data  = shift_nxt;

  // buffer back-pressure seen by the host, from a flop
  always_ff @(posedge ser_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ready_r <= SILD_BIT_RST;
    end else begin
      ready_r <= snap.wr_ready;
    end
  end
  assign ser_ready = ready_r;

  // ************************************************************
  // snapshot buffer
  // ************************************************************
  sild_async_fifo #(
    .WIDTH (CHANNELS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .wr_clk   (ser_clk),
    .wr_rst_n (rst_s2_r),
    .rd_clk   (core_clk),
    .rd_rst_n (rst_c2_r),
    .bus      (snap)
  );

  // ************************************************************
  // core domain: pins, mirror, latches, drivers
  // ************************************************************
  // strobe and enable pins through two flops
  always_ff @(posedge core_clk or negedge rst_c2_r) begin
    if (!rst_c2_r) begin
      stb_s1_r <= SILD_BIT_RST;
      stb_s2_r <= SILD_BIT_RST;
      oe_s1_r  <= SILD_BIT_RST;
      oe_s2_r  <= SILD_BIT_RST;
    end else begin
      stb_s1_r <= strobe;
      stb_s2_r <= stb_s1_r;
      oe_s1_r  <= out_enable;
      oe_s2_r  <= oe_s1_r;
    end
  end

  // drain always; the latest snapshot is the chain state
  assign snap.rd_ready = SILD_BIT_SET;

  always_ff @(posedge core_clk or negedge rst_c2_r) begin
    if (!rst_c2_r) begin
      mirror_r <= CHANNELS'(SILD_WORD_RST);
    end else if (snap.rd_valid) begin
      mirror_r <= snap.rd_data;
    end
  end

  // latches: transparent while strobe high, hold while low
  always_ff @(posedge core_clk or negedge rst_c2_r) begin
    if (!rst_c2_r) begin
      latch_r <= CHANNELS'(SILD_WORD_RST);
    end else if (stb_s2_r) begin
      latch_r <= mirror_r;
    end else begin
      latch_r <= latch_r;
    end
  end

  // per-channel output gating by the enable
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_drv
      always_ff @(posedge core_clk or negedge rst_c2_r) begin
        if (!rst_c2_r) begin
          drive_r[ch] <= SILD_BIT_RST;
        end else if (!oe_s2_r) begin
          drive_r[ch] <= SILD_BIT_RST;
        end else begin
          drive_r[ch] <= latch_r[ch];
        end
      end
    end
  endgenerate
  assign drive_on = drive_r;
endmodule
`default_nettype wire

// [test/sild_drv_sva.sv]
// port assertions for the latched driver
// assumes the host holds ser_clk still between frames
`timescale 1ns/1ps
`default_nettype none
module sild_drv_sva
  import sild_pkg::*;
#(parameter int CHANNELS = SILD_CHANNELS) (
  input wire logic                core_clk,
  input wire logic                resetn,
  input wire logic                ser_clk,
  input wire logic                ser_data_in,
  input wire logic                strobe,
  input wire logic                out_enable,
  input wire logic                ser_data_out,
  input wire logic [CHANNELS-1:0] drive_on
);
  logic [1:0]          rise_r;
  logic [CHANNELS-1:0] chain_r;
  logic [4:0]          idle_r;
  logic                tog_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // chain model, first two rises feed the reset sync
  always_ff @(posedge ser_clk or negedge resetn) begin
    if (!resetn) begin
      rise_r  <= 2'h0;
      chain_r <= '0;
    end else if (rise_r != 2'h2) begin
      rise_r <= rise_r + 2'h1;
    end else begin
      chain_r <= {chain_r[CHANNELS-2:0], ser_data_in};
    end
  end
  // flips on every link rise, so a short clock pulse between samples still shows
  always_ff @(posedge ser_clk or negedge resetn) begin
    if (!resetn) begin
      tog_r <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
    end
  end
  // core cycles without pin activity
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_r <= 5'h0;
    end else if ($changed(ser_clk) || $changed(tog_r) || $changed(strobe) ||
                 $changed(out_enable)) begin
      idle_r <= 5'h0;
    end else if (idle_r != 5'h1f) begin
      idle_r <= idle_r + 5'h1;
    end
  end
  chain_out_a: assert property (idle_r > 5'h2 |-> ser_data_out == chain_r[CHANNELS-1])
    else $error("serial out wrong");
  shift_a: assert property ($changed(tog_r) |-> ser_data_out == chain_r[CHANNELS-1])
    else $error("shift wrong");
  out_hold_a: assert property ($changed(ser_data_out) |-> $changed(tog_r))
    else $error("serial out moved");
  oe_off_a: assert property (!out_enable [*5] |-> drive_on == '0)
    else $error("driver on while disabled");
  follow_a: assert property (idle_r == 5'h14 && strobe && out_enable |-> drive_on == chain_r)
    else $error("drivers not from chain");
  hold_a: assert property ((!strobe && out_enable) [*8] |-> $stable(drive_on))
    else $error("latch moved");
  quiet_a: assert property (idle_r > 5'h13 |-> $stable(drive_on))
    else $error("drivers moved idle");
  copy_a: assert property ($rose(strobe) && out_enable && idle_r > 5'h13
    |-> ##[1:8] drive_on == chain_r) else $error("strobe copy late");
endmodule
bind sild_driver sild_drv_sva #(.CHANNELS(CHANNELS)) u_sva (.core_clk(core_clk),
  .resetn(resetn), .ser_clk(ser_clk), .ser_data_in(ser_data_in), .strobe(strobe),
  .out_enable(out_enable), .ser_data_out(ser_data_out), .drive_on(drive_on));
`default_nettype wire

// [test/sild_host_model.sv]
// host side: serial clock and data, msb first
// assumes the bench calls send_bits
`timescale 1ns/1ps
`default_nettype none
module sild_host_model (
  output logic ser_clk,
  output logic ser_data_in
);
  initial begin
    ser_clk = 1'b0;
    ser_data_in = 1'b0;
  end
  // data set while clock low, slow stretches the low phase
  task automatic send_bits(input logic [31:0] w, input int n, input int slow);
    #7;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data_in = w[i];
      #(24 + slow) ser_clk = 1'b1;
      #24 ser_clk = 1'b0;
    end
    #75 ser_data_in = ~ser_data_in; // line no longer holds a bit
  endtask
endmodule
`default_nettype wire

// [test/sild_driver_tb_top.sv]
// bench for the latched driver with host model and scoreboard
// assumes the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module sild_driver_tb_top
  import sild_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        strobe = 1'b0;
  logic        out_enable = 1'b0;
  logic [31:0] a, b, lat;
  logic [32:0] exp_q[$];
  int          n_fail = 0;
  int          n_compared = 0;
  event        look;
  wire logic   ser_clk, ser_data_in, ser_data_out, ser_ready;
  wire logic [31:0] drive_on;
  always #12.5 core_clk = ~core_clk;
  sild_driver dut (.core_clk(core_clk), .resetn(resetn), .ser_clk(ser_clk),
    .ser_data_in(ser_data_in), .strobe(strobe), .out_enable(out_enable),
    .ser_data_out(ser_data_out), .ser_ready(ser_ready), .drive_on(drive_on));
  sild_host_model host (.ser_clk(ser_clk), .ser_data_in(ser_data_in));
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // note the expected outputs once settled
  task automatic note(input logic sdo, input logic [31:0] d);
    repeat (30) @(negedge core_clk);
    exp_q.push_back({sdo, d});
    -> look;
  endtask
  task automatic pins(input logic s, input logic e);
    @(negedge core_clk);
    strobe = s;
    out_enable = e;
  endtask
  task automatic pulse;
    pins(1'b1, 1'b1);
    repeat (8) @(negedge core_clk);
    pins(1'b0, 1'b1);
  endtask
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // scoreboard takes the oldest note
  always @(look) check("outputs", {ser_data_out, drive_on}, exp_q.pop_front());
  initial begin
    #300us;
    n_fail++;
    final_report();
  end
  initial begin
    a = $urandom(32'h2faf_4aa1);
    lat = SILD_WORD_RST;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    host.send_bits(32'h0000_0000, 2, 0);
    note(1'b0, lat);
    pins(1'b0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      a = $urandom();
      b = k ? $urandom() : 32'hffff_ffff;
      host.send_bits(a, 32, 20 * k);
      note(a[31], lat);
      pulse();
      lat = a;
      note(a[31], lat);
      host.send_bits(b, 32, 0);
      note(b[31], lat);
      pins(1'b0, 1'b0);
      note(b[31], 32'h0);
      pins(1'b0, 1'b1);
      note(b[31], lat);
      pulse();
      lat = b;
      note(b[31], lat);
    end
    pins(1'b1, 1'b0);
    host.send_bits(a, 32, 0);
    note(a[31], 32'h0);
    pins(1'b1, 1'b1);
    note(a[31], a);
    pins(1'b1, 1'b0);
    host.send_bits(b, 8, 0);
    pins(1'b1, 1'b1);
    note(a[23], {a[23:0], b[7:0]});
    @(negedge core_clk);
    final_report();
  end
endmodule
`default_nettype wire
